// ### design/wdrc_pkg.sv
package wdrc_pkg;
   // core clock and watchdog oscillator rates
   localparam int unsigned CLK_FREQ_HZ   = 200000000;
   localparam int unsigned OSC_FREQ_HZ   = 128000;
   localparam int unsigned OSC_DIV       = CLK_FREQ_HZ / OSC_FREQ_HZ;
   localparam int unsigned OSC_DIV_W     = 16;

   // register offsets, data space and short i/o space
   localparam logic [7:0]  IO_SPACE_OFS  = 8'h20;
   localparam logic [7:0]  RC_DATA_OFS   = 8'h54;
   localparam logic [7:0]  RC_IO_OFS     = 8'h34;
   localparam logic [7:0]  WDC_DATA_OFS  = 8'h60;

   // reset values
   localparam logic [7:0]  RC_RESET      = 8'h00;
   localparam logic [7:0]  WDC_RESET     = 8'h00;

   // reset cause field positions
   localparam int unsigned RC_POR_BIT    = 0;
   localparam int unsigned RC_EXT_BIT    = 1;
   localparam int unsigned RC_BOR_BIT    = 2;
   localparam int unsigned RC_WDR_BIT    = 3;

   // watchdog control field positions
   localparam int unsigned WDC_PSEL_LO   = 0;
   localparam int unsigned WDC_RSTEN_BIT = 3;
   localparam int unsigned WDC_CHGEN_BIT = 4;
   localparam int unsigned WDC_PSEL3_BIT = 5;
   localparam int unsigned WDC_IRQEN_BIT = 6;
   localparam int unsigned WDC_IRQF_BIT  = 7;

   // change-enable window and timeout table
   localparam logic [2:0]  CHG_WINDOW    = 3'h4;
   localparam int unsigned CNT_W         = 21;
   localparam logic [CNT_W-1:0] TO_BASE  = 21'h000800;
   localparam logic [3:0]  PSEL_MAX      = 4'h9;
endpackage

// ### design/wdrc_tick_if.sv
`timescale 1ns/1ps
interface wdrc_tick_if;
   logic tick;   // one-cycle pulse per oscillator period

   modport src (output tick);
   modport snk (input tick);
endinterface

// ### design/wdrc_osc_div.sv
`timescale 1ns/1ps
module wdrc_osc_div #(
   parameter int unsigned DIV = wdrc_pkg::OSC_DIV
) (
   input  wire logic core_clk_i,   // core clock
   input  wire logic rst_n_i,      // sync reset, active low
   wdrc_tick_if.src  tick_if       // oscillator tick out
);
   import wdrc_pkg::*;

   logic [OSC_DIV_W-1:0] div_ff;
   logic [OSC_DIV_W-1:0] nxt_div;
   logic                 tick_ff;
   logic                 nxt_tick;

   // divide core clock down to oscillator rate
   always_comb begin
      nxt_tick = 1'b0;
      nxt_div  = div_ff + 16'h0001;
      if (div_ff == OSC_DIV_W'(DIV - 1)) begin
         nxt_div  = '0;
         nxt_tick = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         div_ff  <= '0;
         tick_ff <= 1'b0;
      end else begin
         div_ff  <= nxt_div;
         tick_ff <= nxt_tick;
      end
   end

   assign tick_if.tick = tick_ff;
endmodule // wdrc_osc_div

// ### design/wdrc_top.sv
// Functional notes
// [R1] watchdog reset sets cause bit 3; power-on or written zero clears it
// [R2] brown-out reset sets cause bit 2; power-on or written zero clears it
// [R3] external pin reset sets cause bit 1; power-on or written zero clears it
// [R4] power-on sets cause bit 0; only a written zero clears it
// [R5] reset cause register at data 0x54, short i/o at 0x34
// [R6] software reads then clears the cause register early after startup
// [R7] timeout in interrupt configuration sets irq flag, bit 7
// [R8] irq flag clears on vector execution or on written one
// [R9] irq taken only with flag, irq enable and global enable set
// [R10] combined mode: vector execution clears irq enable and flag
// [R11] combined mode: unserviced flag at next timeout gives system reset
// [R12] software re-arms irq enable after each interrupt, outside handler
// [R13] fuse unprogrammed: reset/irq enables pick stopped, irq, reset, both
// [R14] fuse programmed: always system reset mode
// [R15] clearing reset enable or changing prescale needs change enable set
// [R16] change enable clears itself four clock cycles after being set
// [R17] reset enable forced to one while watchdog cause flag set
// [R18] prescale top bit at bit 5, low three at bits 2:0
// [R19] codes 0..9 give 2048..1048576 oscillator cycles, doubling
// [R20] control register at 0x60; both registers reset to 0x00
// [R21] software writes change and reset enable, then new values in four cycles
// [R22] counter counts ticks of the 128 kHz oscillator
// [R23] fuse programmed: reset enable reads one, irq enable reads zero
// [R24] timeout in reset mode gives one-cycle reset pulse
// [R25] restart command clears the counter before timeout
`timescale 1ns/1ps
module wdrc_top #(
   parameter int unsigned OSC_DIV_P = wdrc_pkg::OSC_DIV   // core cycles per oscillator tick
) (
   input  wire logic       core_clk_i,         // core clock, 200 MHz
   input  wire logic       rst_n_i,            // sync reset, active low
   input  wire logic [7:0] bus_addr_i,         // register address
   input  wire logic       bus_io_i,           // address is short i/o space
   input  wire logic       bus_we_i,           // write strobe
   input  wire logic       bus_re_i,           // read strobe
   input  wire logic [7:0] bus_wdata_i,        // write data
   output logic      [7:0] bus_rdata_o,        // read data, one cycle later
   input  wire logic       restart_i,          // watchdog restart pulse
   input  wire logic       irq_ack_i,          // watchdog vector executed
   input  wire logic       global_irq_en_i,    // core status irq enable bit
   input  wire logic       always_on_fuse_i,   // fuse pin, 0 = programmed
   input  wire logic       por_event_i,        // power-on reset seen
   input  wire logic       ext_reset_event_i,  // external pin reset seen
   input  wire logic       brownout_event_i,   // brown-out reset seen
   output logic            irq_req_o,          // watchdog irq request
   output logic            wdt_reset_o         // one-cycle system reset pulse
);
   import wdrc_pkg::*;

   wdrc_tick_if tick_if ();

   // oscillator tick source
   wdrc_osc_div #(
      .DIV        (OSC_DIV_P)
   ) u_osc_div (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .tick_if    (tick_if)
   );

   // fuse pin synchroniser
   // resets to unprogrammed, so the fuse acts two edges after release
   logic fuse_s1_ff;
   logic fuse_s2_ff;

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         fuse_s1_ff <= 1'b1;
         fuse_s2_ff <= 1'b1;
      end else begin
         fuse_s1_ff <= always_on_fuse_i;
         fuse_s2_ff <= fuse_s1_ff;
      end
   end

   // state registers
   logic [3:0]       cause_ff;
   logic [3:0]       nxt_cause;
   logic             irqf_ff;
   logic             nxt_irqf;
   logic             irqen_ff;
   logic             nxt_irqen;
   logic             rsten_ff;
   logic             nxt_rsten;
   logic             chgen_ff;
   logic             nxt_chgen;
   logic [2:0]       chg_cnt_ff;
   logic [2:0]       nxt_chg_cnt;
   logic [3:0]       psel_ff;
   logic [3:0]       nxt_psel;
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic [7:0]       rdata_ff;
   logic [7:0]       nxt_rdata;
   logic             irq_req_ff;
   logic             nxt_irq_req;
   logic             wrst_ff;
   logic             nxt_wrst;

   // decoded and effective values
   logic             rc_hit;
   logic             wdc_hit;
   logic             fuse_prog;
   logic             eff_rsten;
   logic             eff_irqen;
   logic             running;
   logic [3:0]       psel_use;
   logic [CNT_W-1:0] limit;
   logic             timeout;
   logic             to_irq;
   logic             to_rst;
   logic [7:0]       rc_val;
   logic [7:0]       wdc_val;

   // register address decode, data space and short i/o space
   always_comb begin
      rc_hit  = 1'b0;
      wdc_hit = 1'b0;
      if (!bus_io_i && bus_addr_i == RC_DATA_OFS) begin
         rc_hit = 1'b1;                                   // [R5]
      end else if (bus_io_i && bus_addr_i == RC_IO_OFS) begin
         rc_hit = 1'b1;                                   // [R5]
      end else if (!bus_io_i && bus_addr_i == WDC_DATA_OFS) begin
         wdc_hit = 1'b1;                                  // [R20]
      end
   end

   // effective mode, timeout limit and timeout actions
   always_comb begin
      fuse_prog = !fuse_s2_ff;
      eff_rsten = fuse_prog | rsten_ff | cause_ff[RC_WDR_BIT]; // [R14] [R17] [R23]
      eff_irqen = !fuse_prog & irqen_ff;                   // [R23]
      running   = eff_rsten | eff_irqen;                   // [R13]
      // reserved prescale codes time out like the longest valid code
      psel_use  = (psel_ff > PSEL_MAX) ? PSEL_MAX : psel_ff;
      limit     = TO_BASE << psel_use;                     // [R19]
      timeout   = running && tick_if.tick && (cnt_ff == limit - 21'h000001); // [R22]
      // interrupt on first timeout, reset if flag still pending in combined mode
      to_irq    = timeout && eff_irqen && !(eff_rsten && irqf_ff);         // [R7]
      to_rst    = timeout && eff_rsten && (!eff_irqen || irqf_ff);         // [R11] [R24]
   end

   // register read views
   always_comb begin
      rc_val    = {4'h0, cause_ff};
      wdc_val   = 8'h00;
      wdc_val[WDC_IRQF_BIT]             = irqf_ff;
      wdc_val[WDC_IRQEN_BIT]            = eff_irqen;
      wdc_val[WDC_PSEL3_BIT]            = psel_ff[3];    // [R18]
      wdc_val[WDC_CHGEN_BIT]            = chgen_ff;
      wdc_val[WDC_RSTEN_BIT]            = eff_rsten;
      wdc_val[WDC_PSEL_LO +: 3]         = psel_ff[2:0];  // [R18]
   end

   // reset cause flags
   always_comb begin
      nxt_cause = cause_ff;
      // written zeros clear, written ones keep
      if (bus_we_i && rc_hit) begin
         nxt_cause = cause_ff & bus_wdata_i[3:0];          // [R1] [R2] [R3] [R4]
      end
      if (ext_reset_event_i) begin
         nxt_cause[RC_EXT_BIT] = 1'b1;                     // [R3]
      end
      if (brownout_event_i) begin
         nxt_cause[RC_BOR_BIT] = 1'b1;                     // [R2]
      end
      if (to_rst) begin
         nxt_cause[RC_WDR_BIT] = 1'b1;                     // [R1]
      end
      // power-on wins over every other event and write
      if (por_event_i) begin
         nxt_cause = 4'h0;                                 // [R1] [R2] [R3]
         nxt_cause[RC_POR_BIT] = 1'b1;                     // [R4]
      end
   end

   // watchdog control register, change-enable window
   always_comb begin
      nxt_irqf    = irqf_ff;
      nxt_irqen   = irqen_ff;
      nxt_rsten   = rsten_ff;
      nxt_psel    = psel_ff;
      nxt_chgen   = chgen_ff;
      nxt_chg_cnt = chg_cnt_ff;
      if (chgen_ff) begin
         if (chg_cnt_ff == 3'h1) begin
            nxt_chgen = 1'b0;                              // [R16]
         end
         nxt_chg_cnt = chg_cnt_ff - 3'h1;
      end
      // vector execution clears the flag, in combined mode the enable too
      if (irq_ack_i) begin
         nxt_irqf = 1'b0;                                  // [R8]
         if (eff_rsten) begin
            nxt_irqen = 1'b0;                              // [R10]
         end
      end
      if (bus_we_i && wdc_hit) begin
         if (bus_wdata_i[WDC_IRQF_BIT]) begin
            nxt_irqf = 1'b0;                               // [R8]
         end
         nxt_irqen = bus_wdata_i[WDC_IRQEN_BIT];
         if (chgen_ff) begin
            // inside the window: full update accepted
            nxt_rsten = bus_wdata_i[WDC_RSTEN_BIT];        // [R15]
            nxt_psel  = {bus_wdata_i[WDC_PSEL3_BIT], bus_wdata_i[WDC_PSEL_LO +: 3]}; // [R15] [R18]
         end else begin
            nxt_rsten = rsten_ff | bus_wdata_i[WDC_RSTEN_BIT]; // [R15]
         end
         if (bus_wdata_i[WDC_CHGEN_BIT]) begin
            nxt_chgen   = 1'b1;
            nxt_chg_cnt = CHG_WINDOW;                      // [R16]
         end else begin
            nxt_chgen   = 1'b0;
         end
      end
      if (cause_ff[RC_WDR_BIT]) begin
         nxt_rsten = 1'b1;                                 // [R17]
      end
      // hardware set of the flag wins over a same-cycle clear
      if (to_irq) begin
         nxt_irqf = 1'b1;                                  // [R7]
      end
   end

   // watchdog counter, cleared by restart, stop or timeout
   always_comb begin
      nxt_cnt = cnt_ff;
      if (restart_i || !running || timeout) begin
         nxt_cnt = '0;                                     // [R25]
      end else if (tick_if.tick) begin
         nxt_cnt = cnt_ff + 21'h000001;                    // [R22]
      end
   end

   // read data and output strobes
   always_comb begin
      nxt_rdata = 8'h00;
      if (bus_re_i && rc_hit) begin
         nxt_rdata = rc_val;
      end else if (bus_re_i && wdc_hit) begin
         nxt_rdata = wdc_val;
      end
      nxt_irq_req = irqf_ff && eff_irqen && global_irq_en_i && !irq_ack_i; // [R9]
      nxt_wrst    = to_rst;                                // [R24]
   end

   // reset cause register
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         cause_ff   <= RC_RESET[3:0];                      // [R20]
      end else begin
         cause_ff   <= nxt_cause;
      end
   end

   // watchdog control register and change window
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         irqf_ff    <= WDC_RESET[WDC_IRQF_BIT];            // [R20]
         irqen_ff   <= WDC_RESET[WDC_IRQEN_BIT];
         rsten_ff   <= WDC_RESET[WDC_RSTEN_BIT];
         chgen_ff   <= WDC_RESET[WDC_CHGEN_BIT];
         psel_ff    <= {WDC_RESET[WDC_PSEL3_BIT], WDC_RESET[2:0]};
         chg_cnt_ff <= 3'h0;
      end else begin
         irqf_ff    <= nxt_irqf;
         irqen_ff   <= nxt_irqen;
         rsten_ff   <= nxt_rsten;
         chgen_ff   <= nxt_chgen;
         psel_ff    <= nxt_psel;
         chg_cnt_ff <= nxt_chg_cnt;
      end
   end

   // watchdog counter
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         cnt_ff     <= '0;
      end else begin
         cnt_ff     <= nxt_cnt;
      end
   end

   // read data and output strobes
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         rdata_ff   <= 8'h00;
         irq_req_ff <= 1'b0;
         wrst_ff    <= 1'b0;
      end else begin
         rdata_ff   <= nxt_rdata;
         irq_req_ff <= nxt_irq_req;
         wrst_ff    <= nxt_wrst;
      end
   end

   // outputs straight from their flip-flops
   assign bus_rdata_o = rdata_ff;
   assign irq_req_o   = irq_req_ff;
   assign wdt_reset_o = wrst_ff;
endmodule // wdrc_top

// ### tb/wdrc_props.sv
`timescale 1ns/1ps
module wdrc_props #(
   parameter int unsigned OSC_DIV_P = 2   // core cycles per tick
) (
   input wire logic       core_clk_i,        // clock
   input wire logic       rst_n_i,           // reset
   input wire logic [7:0] bus_addr_i,        // address
   input wire logic       bus_io_i,          // i/o space
   input wire logic       bus_we_i,          // write
   input wire logic       bus_re_i,          // read
   input wire logic [7:0] bus_wdata_i,       // write data
   input wire logic [7:0] bus_rdata_o,       // read data
   input wire logic       irq_ack_i,         // vector taken
   input wire logic       global_irq_en_i,   // global enable
   input wire logic       always_on_fuse_i,  // fuse
   input wire logic       por_event_i,       // power-on
   input wire logic       irq_req_o,         // irq
   input wire logic       wdt_reset_o        // reset pulse
);
   // one clock domain
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   // decoded accesses
   wire rd_rc  = bus_re_i && !bus_io_i && bus_addr_i == 8'h54;
   wire rd_wc  = bus_re_i && !bus_io_i && bus_addr_i == 8'h60;
   wire wr_chg = bus_we_i && !bus_io_i && bus_addr_i == 8'h60 && bus_wdata_i[4];
   a_rdata_idle: assert property (!bus_re_i |=> bus_rdata_o == 8'h00)
      else $error("read data not idle");
   a_cause_upper_zero: assert property (rd_rc |=> bus_rdata_o[7:4] == 4'h0)
      else $error("cause upper bits set");
   a_por_flag_set: assert property (por_event_i ##1 rd_rc |=> bus_rdata_o[0])
      else $error("power-on flag missing");
   a_chg_reads_set: assert property (wr_chg ##1 !bus_we_i ##1 rd_wc |=> bus_rdata_o[4])
      else $error("change enable not set");
   a_chg_self_clear: assert property (wr_chg ##1 !bus_we_i[*4] ##1 rd_wc |=> !bus_rdata_o[4])
      else $error("change enable not cleared");
   a_irq_needs_gie: assert property (irq_req_o |-> $past(global_irq_en_i))
      else $error("irq without global enable");
   a_ack_drops_irq: assert property (irq_ack_i |=> !irq_req_o)
      else $error("irq held after ack");
   a_fuse_no_irq: assert property (!always_on_fuse_i[*4] |-> !irq_req_o)
      else $error("irq with fuse programmed");
   a_reset_one_cycle: assert property (wdt_reset_o |=> !wdt_reset_o)
      else $error("reset pulse too long");
endmodule // wdrc_props

bind wdrc_top wdrc_props #(.OSC_DIV_P(OSC_DIV_P)) i_wdrc_props (
   .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .bus_addr_i(bus_addr_i),
   .bus_io_i(bus_io_i), .bus_we_i(bus_we_i), .bus_re_i(bus_re_i),
   .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o), .irq_ack_i(irq_ack_i),
   .global_irq_en_i(global_irq_en_i), .always_on_fuse_i(always_on_fuse_i),
   .por_event_i(por_event_i), .irq_req_o(irq_req_o), .wdt_reset_o(wdt_reset_o));

// ### tb/wdrc_top_tb.sv
`timescale 1ns/1ps
module wdrc_top_tb;
   logic       core_clk_i = 1'b0;
   logic       rst_n_i = 1'b0;
   logic [7:0] bus_addr_i = 8'h00;
   logic       bus_io_i = 1'b0;
   logic       bus_we_i = 1'b0;
   logic       bus_re_i = 1'b0;
   logic [7:0] bus_wdata_i = 8'h00;
   logic [7:0] bus_rdata_o;
   logic       restart_i = 1'b0;
   logic       irq_ack_i = 1'b0;
   logic       global_irq_en_i = 1'b0;
   logic       always_on_fuse_i = 1'b1;
   logic       por_event_i = 1'b0;
   logic       ext_reset_event_i = 1'b0;
   logic       brownout_event_i = 1'b0;
   logic       irq_req_o;
   logic       wdt_reset_o;
   int         error_cnt = 0;
   int         checked = 0;

   // design with a two-cycle oscillator tick
   wdrc_top #(.OSC_DIV_P(2)) i_wdrc_top (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .bus_addr_i(bus_addr_i),
      .bus_io_i(bus_io_i), .bus_we_i(bus_we_i), .bus_re_i(bus_re_i),
      .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o), .restart_i(restart_i),
      .irq_ack_i(irq_ack_i), .global_irq_en_i(global_irq_en_i),
      .always_on_fuse_i(always_on_fuse_i), .por_event_i(por_event_i),
      .ext_reset_event_i(ext_reset_event_i), .brownout_event_i(brownout_event_i),
      .irq_req_o(irq_req_o), .wdt_reset_o(wdt_reset_o));

   // 200 mhz clock
   always #2.5 core_clk_i = ~core_clk_i;

   // verdict and end of run
   task automatic close_out();
      if (error_cnt == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // advance n edges, inputs move 1 ns later
   task automatic step(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      step(1);
      s = 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus_addr_i = a;
      bus_wdata_i = d;
      bus_we_i = 1'b1;
      step(1);
      bus_we_i = 1'b0;
      step(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic io, input logic [7:0] e, input string nm);
      bus_addr_i = a;
      bus_io_i = io;
      bus_re_i = 1'b1;
      step(1);
      bus_re_i = 1'b0;
      bus_io_i = 1'b0;
      chk(nm, e, bus_rdata_o);
      step(1);
   endtask
   // bounded wait for irq (sel 0) or reset pulse (sel 1)
   task automatic wait_hi(input logic sel, input int lo, input int hi, input string nm);
      int n;
      n = 0;
      while ((sel ? wdt_reset_o : irq_req_o) !== 1'b1 && n < hi) begin
         step(1);
         n++;
      end
      chk(nm, 8'h01, {7'h00, n >= lo && n < hi});
   endtask

   task automatic t_cause();
      rd(8'h54, 1'b0, 8'h00, "cause reset");
      rd(8'h60, 1'b0, 8'h00, "ctrl reset");
      rd(8'h10, 1'b0, 8'h00, "unmapped");
      pulse(por_event_i);
      rd(8'h54, 1'b0, 8'h01, "por flag");
      pulse(ext_reset_event_i);
      pulse(brownout_event_i);
      rd(8'h34, 1'b1, 8'h07, "io cause");
      wr(8'h54, 8'hfe);
      rd(8'h54, 1'b0, 8'h06, "por cleared");
      pulse(por_event_i);
      rd(8'h54, 1'b0, 8'h01, "por wipes");
      wr(8'h54, 8'h00);
   endtask
   task automatic t_seq();
      wr(8'h60, 8'h08);
      wr(8'h60, 8'h01);
      rd(8'h60, 1'b0, 8'h08, "locked");
      wr(8'h60, 8'h18);
      rd(8'h60, 1'b0, 8'h18, "chg set");
      wr(8'h60, 8'h01);
      rd(8'h60, 1'b0, 8'h01, "timed change");
      wr(8'h60, 8'h19);
      step(3);
      rd(8'h60, 1'b0, 8'h09, "chg expired");
      wr(8'h60, 8'h19);
      wr(8'h60, 8'h01);
   endtask
   task automatic t_irq();
      global_irq_en_i = 1'b1;
      wr(8'h60, 8'h41);
      pulse(restart_i);
      step(3000);
      pulse(restart_i);
      wait_hi(1'b0, 8176, 8210, "irq time");
      rd(8'h60, 1'b0, 8'hc1, "irq flag");
      global_irq_en_i = 1'b0;
      step(2);
      chk("irq gated", 8'h00, {7'h00, irq_req_o});
      global_irq_en_i = 1'b1;
      pulse(irq_ack_i);
      rd(8'h60, 1'b0, 8'h41, "ack clears");
      wr(8'h60, 8'h49);
      pulse(restart_i);
      wait_hi(1'b0, 8176, 8210, "combined irq");
      pulse(irq_ack_i);
      rd(8'h60, 1'b0, 8'h09, "combined ack");
      wr(8'h60, 8'h49);
      pulse(restart_i);
      wait_hi(1'b0, 8176, 8210, "rearmed irq");
      wait_hi(1'b1, 8176, 8210, "unserviced reset");
      pulse(irq_ack_i);
      wr(8'h54, 8'h00);
      pulse(restart_i);
      wait_hi(1'b1, 8176, 8210, "reset time");
      rd(8'h54, 1'b0, 8'h08, "wd cause");
      wr(8'h60, 8'h19);
      wr(8'h60, 8'h01);
      rd(8'h60, 1'b0, 8'h09, "rsten forced");
      wr(8'h54, 8'h00);
      wr(8'h60, 8'h19);
      wr(8'h60, 8'h00);
      rd(8'h60, 1'b0, 8'h00, "wd off");
   endtask
   task automatic t_fuse();
      always_on_fuse_i = 1'b0;
      wr(8'h60, 8'h40);
      step(2);
      rd(8'h60, 1'b0, 8'h08, "fuse lock");
      pulse(restart_i);
      wait_hi(1'b1, 4080, 4112, "fuse reset");
      always_on_fuse_i = 1'b1;
   endtask

   // main sequence
   initial begin
      step(6);
      rst_n_i = 1'b1;
      step(1);
      t_cause();
      t_seq();
      t_irq();
      t_fuse();
      close_out();
   end
   // hang guard, about twice the expected run
   initial begin
      step(90000);
      error_cnt++;
      close_out();
   end
endmodule // wdrc_top_tb
